// *** saer_pkg.sv ***
// Purpose: shared constants and types for the shared address event responder
// Assumes: registers are 16-bit words addressed by their protocol register number
// Notes:   the timeout register counts milliseconds
`default_nettype none
package saer_pkg;
    localparam logic [15:0] REG_UNIT_ADDR    = 16'h1F04;
    localparam logic [15:0] REG_OUT_STATE    = 16'h1F05;
    localparam logic [15:0] REG_WIN_LAST     = 16'h1F06;
    localparam logic [15:0] REG_JOB_FIRST    = 16'h21FC;
    localparam logic [15:0] REG_JOB_LAST     = 16'h2230;
    localparam logic [15:0] REG_GROUP_ADDR   = 16'h226A;
    localparam logic [15:0] REG_LATCH_TMO    = 16'h226C;
    localparam logic [7:0]  UNIT_ADDR_RST    = 8'h01;
    localparam logic [7:0]  GROUP_ADDR_RST   = 8'hC3;
    localparam logic [15:0] LATCH_TMO_RST    = 16'h03E8;
    localparam logic [15:0] WORD_ZERO        = 16'h0000;
    localparam logic [7:0]  EXC_NONE         = 8'h00;
    localparam logic [7:0]  EXC_ILLEGAL_ADDR = 8'h02;
    localparam int          CLK_MHZ          = 100;
    localparam int          MS_NS            = 1000000;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          MS_CYCLES        = MS_NS / CLK_PERIOD_NS;
    localparam int          SLOTS            = 8;
    localparam logic [2:0]  SLOT_UNIT        = 3'h0;
    localparam logic [2:0]  SLOT_STATE       = 3'h1;
    localparam logic [2:0]  SLOT_WIN2        = 3'h2;
    localparam logic [2:0]  SLOT_JOB         = 3'h3;
    localparam logic [2:0]  SLOT_GROUP       = 3'h4;
    localparam logic [2:0]  SLOT_TMO         = 3'h5;
    localparam logic [2:0]  SLOT_NONE        = 3'h7;

    typedef struct packed {
        logic        valid;
        logic [7:0]  busAddr;
        logic        write;
        logic [15:0] regNum;
        logic [15:0] data;
    } saer_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  exception;
        logic [15:0] data;
    } saer_rsp_t;
endpackage
`default_nettype wire

// *** saer_regmem.sv ***
// Purpose: small register store with registered read data
// Assumes: one write and one read port, single clock
// Notes:   read data appear one enabled cycle after the address
`timescale 1ns/1ps
`default_nettype none
module saer_regmem (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clkEn,
    input  wire logic        wrEn,
    input  wire logic [2:0]  wrSlot,
    input  wire logic [15:0] wrData,
    input  wire logic [2:0]  rdSlot,
    output logic      [15:0] rdData
);
    logic [15:0] mem [saer_pkg::SLOTS];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < saer_pkg::SLOTS; i++) begin
                mem[i] <= saer_pkg::WORD_ZERO;
            end
            rdData <= saer_pkg::WORD_ZERO;
        end else if (clkEn) begin
            if (wrEn) begin
                mem[wrSlot] <= wrData;
            end
            rdData <= mem[rdSlot];
        end
    end
endmodule
`default_nettype wire

// *** saer_responder.sv ***
// Purpose: address filter and actuation latch for a polled multidrop device
// Assumes: frames already decoded into one-cycle requests; all inputs synchronous
// Notes:   answers take three enabled cycles; live registers override stored copies
// Function
// - always answer own unit address
// - shared address answered only while latched
// - shared address reaches only window registers
// - window register holds unit bus address
// - actuation loads nonzero sensor code
// - latch holds until zero write, job range write or timeout
// - job range writes clear the latch
// - timeout length from timeout register
// - shared address taken from group register
`timescale 1ns/1ps
`default_nettype none
module saer_responder (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 clkEn,
    input  wire saer_pkg::saer_req_t  req,
    input  wire logic                 actuate,
    input  wire logic [15:0]          sensorCode,
    output saer_pkg::saer_rsp_t       rsp,
    output logic                      latched
);
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_REPLY} saer_state_t;

    saer_state_t state;
    logic [7:0]  unitAddr;
    logic [7:0]  groupAddr;
    logic [15:0] latchTmo;
    logic [15:0] outState;
    logic [31:0] msCount;
    logic [15:0] msElapsed;
    logic        pendWrite;
    logic [7:0]  pendExc;
    logic [15:0] pendReg;
    logic [15:0] memRd;

    function automatic logic [2:0] slotOf(input logic [15:0] r);
        logic [2:0] s;
        s = saer_pkg::SLOT_NONE;
        if (r == saer_pkg::REG_UNIT_ADDR) s = saer_pkg::SLOT_UNIT;
        else if (r == saer_pkg::REG_OUT_STATE) s = saer_pkg::SLOT_STATE;
        else if (r == saer_pkg::REG_WIN_LAST) s = saer_pkg::SLOT_WIN2;
        else if (r >= saer_pkg::REG_JOB_FIRST && r <= saer_pkg::REG_JOB_LAST) s = saer_pkg::SLOT_JOB;
        else if (r == saer_pkg::REG_GROUP_ADDR) s = saer_pkg::SLOT_GROUP;
        else if (r == saer_pkg::REG_LATCH_TMO) s = saer_pkg::SLOT_TMO;
        return s;
    endfunction

    wire logic        isLatched = (outState != saer_pkg::WORD_ZERO);
    wire logic        toUnit    = req.valid && (req.busAddr == unitAddr);
    wire logic        toGroup   = req.valid && !toUnit && isLatched
                                  && (req.busAddr == groupAddr);
    wire logic        inWindow  = (req.regNum >= saer_pkg::REG_UNIT_ADDR)
                                  && (req.regNum <= saer_pkg::REG_WIN_LAST);
    wire logic        accept    = (state == ST_IDLE) && (toUnit || toGroup);
    wire logic        groupBad  = toGroup && !inWindow;
    wire logic        doWrite   = accept && req.write && !groupBad;
    wire logic [2:0]  reqSlot   = slotOf(req.regNum);
    wire logic        clrByJob  = doWrite && (reqSlot == saer_pkg::SLOT_JOB);
    wire logic        clrByZero = doWrite && (req.regNum == saer_pkg::REG_OUT_STATE)
                                  && (req.data == saer_pkg::WORD_ZERO);
    wire logic        msTick    = (msCount == 32'(saer_pkg::MS_CYCLES - 1));
    wire logic        timedOut  = isLatched && msTick
                                  && (msElapsed + 16'h0001 >= latchTmo);
    wire logic [2:0]  pendSlot  = slotOf(pendReg);
    wire logic [15:0] liveData  = (pendSlot == saer_pkg::SLOT_UNIT)  ? {8'h00, unitAddr} :
                                  (pendSlot == saer_pkg::SLOT_STATE) ? outState :
                                  (pendSlot == saer_pkg::SLOT_GROUP) ? {8'h00, groupAddr} :
                                  (pendSlot == saer_pkg::SLOT_TMO)   ? latchTmo : memRd;
    wire logic        memWr     = doWrite && (reqSlot != saer_pkg::SLOT_NONE);

    saer_regmem u_mem (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .wrEn    (memWr),
        .wrSlot  (reqSlot),
        .wrData  (req.data),
        .rdSlot  (pendSlot),
        .rdData  (memRd)
    );

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            unitAddr  <= saer_pkg::UNIT_ADDR_RST;
            groupAddr <= saer_pkg::GROUP_ADDR_RST;
            latchTmo  <= saer_pkg::LATCH_TMO_RST;
        end else if (clkEn && doWrite) begin
            if (req.regNum == saer_pkg::REG_UNIT_ADDR) unitAddr <= req.data[7:0];
            if (req.regNum == saer_pkg::REG_GROUP_ADDR) groupAddr <= req.data[7:0];
            if (req.regNum == saer_pkg::REG_LATCH_TMO) latchTmo <= req.data;
        end
    end

    // event load wins over any clear arriving in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            outState <= saer_pkg::WORD_ZERO;
        end else if (clkEn) begin
            if (actuate && sensorCode != saer_pkg::WORD_ZERO) outState <= sensorCode;
            else if (clrByJob || clrByZero || timedOut) outState <= saer_pkg::WORD_ZERO;
            else if (doWrite && req.regNum == saer_pkg::REG_OUT_STATE) outState <= req.data;
        end
    end

    // timeout counter restarts whenever a new event is loaded
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            msCount   <= 32'h00000000;
            msElapsed <= saer_pkg::WORD_ZERO;
        end else if (clkEn) begin
            if (!isLatched || (actuate && sensorCode != saer_pkg::WORD_ZERO)) begin
                msCount   <= 32'h00000000;
                msElapsed <= saer_pkg::WORD_ZERO;
            end else if (msTick) begin
                msCount   <= 32'h00000000;
                msElapsed <= msElapsed + 16'h0001;
            end else begin
                msCount <= msCount + 32'h00000001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state     <= ST_IDLE;
            pendWrite <= 1'b0;
            pendExc   <= saer_pkg::EXC_NONE;
            pendReg   <= saer_pkg::WORD_ZERO;
            rsp       <= '0;
            latched   <= 1'b0;
        end else if (clkEn) begin
            latched <= isLatched;
            rsp.valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state     <= ST_READ;
                        pendWrite <= req.write;
                        pendReg   <= req.regNum;
                        pendExc   <= groupBad ? saer_pkg::EXC_ILLEGAL_ADDR
                                              : saer_pkg::EXC_NONE;
                    end
                end
                ST_READ: begin
                    state <= ST_REPLY;
                end
                ST_REPLY: begin
                    state         <= ST_IDLE;
                    rsp.valid     <= 1'b1;
                    rsp.exception <= pendExc;
                    rsp.data      <= (pendWrite || pendExc != saer_pkg::EXC_NONE)
                                     ? saer_pkg::WORD_ZERO : liveData;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // a take, then two more enabled cycles, then the reply
    sequence s_take;
        clkEn && accept;
    endsequence
    sequence s_busy_two;
        clkEn ##1 clkEn;
    endsequence

    a_group_silent: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clkEn && req.valid && req.busAddr != unitAddr && !isLatched && state == ST_IDLE)
        |=> state == ST_IDLE)
        else $error("answered group address while unlatched");
    a_unit_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clkEn && req.valid && req.busAddr == unitAddr && state == ST_IDLE)
        |=> state == ST_READ)
        else $error("own address not accepted");
    a_window_exc: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clkEn && groupBad && state == ST_IDLE) |=> pendExc == saer_pkg::EXC_ILLEGAL_ADDR)
        else $error("missing exception outside window");
    a_actuate_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clkEn && actuate && sensorCode != saer_pkg::WORD_ZERO)
        |=> outState == $past(sensorCode))
        else $error("sensor code not latched");
    a_job_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clkEn && clrByJob && !actuate) |=> outState == saer_pkg::WORD_ZERO)
        else $error("job write did not clear");
    a_zero_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clkEn && clrByZero && !actuate) |=> !isLatched)
        else $error("zero write kept latch");
    a_timeout_clr: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clkEn && timedOut && !actuate) |=> !isLatched)
        else $error("timeout did not clear");
    a_group_take: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clkEn && doWrite && req.regNum == saer_pkg::REG_GROUP_ADDR)
        |=> groupAddr == $past(req.data[7:0]))
        else $error("group address not taken");
    a_reply_time: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_take ##1 s_busy_two |=> rsp.valid)
        else $error("reply late");
    a_reply_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clkEn && rsp.valid) |=> !rsp.valid)
        else $error("reply longer than one cycle");
    a_exc_nodata: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (rsp.valid && rsp.exception != saer_pkg::EXC_NONE)
        |-> rsp.data == saer_pkg::WORD_ZERO)
        else $error("exception reply carries data");
    a_latch_mirror: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clkEn |=> latched == $past(isLatched))
        else $error("latched output does not follow state");
    a_window_nowrite: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clkEn && groupBad && req.write && state == ST_IDLE)
        |=> (latchTmo == $past(latchTmo)) && (groupAddr == $past(groupAddr)))
        else $error("write outside window took effect");
endmodule
`default_nettype wire

// *** saer_master_model.sv ***
// Purpose: polling bus master that issues decoded requests to the responder
// Assumes: one request in flight; answer comes three enabled cycles after the take
// Notes:   expected answers are queued for the bench's watcher
`timescale 1ns/1ps
`default_nettype none
module saer_master_model (
    input  wire logic           clk_sys,
    output saer_pkg::saer_req_t req
);
    logic [23:0] expQ[$];
    initial req = '0;
    // request lasts one cycle, then fields are scrambled so stale values never match
    task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] r,
                        input logic [15:0] d, input logic ans, input logic [23:0] e);
        @(posedge clk_sys);
        #1;
        req = '{valid: 1'b1, busAddr: a, write: w, regNum: r, data: d};
        if (ans) expQ.push_back(e);
        @(posedge clk_sys);
        #1;
        req = {1'b0, ~req[40:0]};
        repeat (4) @(posedge clk_sys);
    endtask
    // poll reads identity and state; a silent poll is normal
    task automatic poll(input logic [7:0] a, input logic ans, input logic [15:0] id,
                        input logic [15:0] st);
        xfer(a, 1'b0, saer_pkg::REG_UNIT_ADDR, 16'h0000, ans, {saer_pkg::EXC_NONE, id});
        xfer(a, 1'b0, saer_pkg::REG_OUT_STATE, 16'h0000, ans, {saer_pkg::EXC_NONE, st});
    endtask
endmodule
`default_nettype wire

// *** tb_shared_address_event_responder.sv ***
// Purpose: self-checking bench for the shared address event responder
// Assumes: master model drives requests; bench drives sensor events
// Notes:   latch timeout of zero clears at the first millisecond tick
`timescale 1ns/1ps
`default_nettype none
module tb_shared_address_event_responder;
    localparam logic [7:0] UA = saer_pkg::UNIT_ADDR_RST;
    localparam logic [7:0] GA = saer_pkg::GROUP_ADDR_RST;
    localparam logic [23:0] OK0 = {saer_pkg::EXC_NONE, 16'h0000};
    logic                clk_sys;
    logic                reset_n;
    logic                clkEn;
    logic                actuate;
    logic [15:0]         sensorCode;
    logic [15:0]         code;
    logic [15:0]         rs;
    logic [7:0]          other;
    logic [15:0]         win;
    logic [15:0]         jobData;
    int                  failures;
    int                  checksDone;
    int                  cycles;
    int                  n;
    saer_pkg::saer_req_t req;
    saer_pkg::saer_rsp_t rsp;
    logic                latched;
    logic [23:0]         expv;

    saer_responder DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .req(req),
        .actuate(actuate), .sensorCode(sensorCode), .rsp(rsp), .latched(latched));
    saer_master_model master (.clk_sys(clk_sys), .req(req));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] xs();
        rs = rs ^ (rs << 7);
        rs = rs ^ (rs >> 9);
        rs = rs ^ (rs << 8);
        return rs;
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && checksDone > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic act(input logic [15:0] c);
        @(posedge clk_sys);
        #1;
        actuate = 1'b1;
        sensorCode = c;
        @(posedge clk_sys);
        #1;
        actuate = 1'b0;
        sensorCode = ~c;
        repeat (2) @(posedge clk_sys);
        check({23'h0, latched}, 24'h1);
    endtask

    // every answer must match the oldest queued expectation
    always @(posedge clk_sys) begin
        if (reset_n === 1'b1 && rsp.valid === 1'b1) begin
            expv = (master.expQ.size() > 0) ? master.expQ.pop_front() : 24'hXXXXXX;
            check({rsp.exception, rsp.data}, expv);
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 101500) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        rs = 16'h0050;
        reset_n = 1'b0;
        clkEn = 1'b1;
        actuate = 1'b0;
        sensorCode = 16'h0000;
        repeat (8) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        clkEn = 1'b0;
        // frozen block must not take this request, so no answer is queued
        master.xfer(UA, 1'b0, saer_pkg::REG_UNIT_ADDR, 16'h0, 1'b0, OK0);
        #1;
        clkEn = 1'b1;
        master.xfer(UA, 1'b0, saer_pkg::REG_GROUP_ADDR, 16'h0, 1'b1, {8'h00, 8'h00, GA});
        master.xfer(UA, 1'b0, saer_pkg::REG_LATCH_TMO, 16'h0, 1'b1,
                    {8'h00, saer_pkg::LATCH_TMO_RST});
        // ten polls of 100 ms before an event may expire
        master.xfer(UA, 1'b1, saer_pkg::REG_LATCH_TMO, 16'h03E8, 1'b1, OK0);
        win = xs();
        master.xfer(UA, 1'b1, saer_pkg::REG_WIN_LAST, win, 1'b1, OK0);
        master.poll(UA, 1'b1, {8'h00, UA}, 16'h0000);
        master.poll(GA, 1'b0, 16'h0, 16'h0);
        code = xs() | 16'h0001;
        act(code);
        master.poll(GA, 1'b1, {8'h00, UA}, code);
        master.xfer(GA, 1'b0, saer_pkg::REG_WIN_LAST, 16'h0, 1'b1, {8'h00, win});
        master.xfer(GA, 1'b0, saer_pkg::REG_JOB_FIRST, 16'h0, 1'b1, {8'h02, 16'h0});
        master.xfer(GA, 1'b0, saer_pkg::REG_LATCH_TMO, 16'h0, 1'b1, {8'h02, 16'h0});
        other = (xs() & 16'h007F) | 16'h0004;
        master.poll(other, 1'b0, 16'h0, 16'h0);
        // acknowledge through the unit address only
        jobData = xs();
        master.xfer(UA, 1'b1, saer_pkg::REG_JOB_FIRST + (xs() % 16'h0035), jobData, 1'b1, OK0);
        check({23'h0, latched}, 24'h0);
        master.xfer(UA, 1'b0, saer_pkg::REG_JOB_LAST, 16'h0, 1'b1, {8'h00, jobData});
        master.poll(GA, 1'b0, 16'h0, 16'h0);
        master.xfer(UA, 1'b1, saer_pkg::REG_GROUP_ADDR, 16'h0055, 1'b1, OK0);
        code = xs() | 16'h0002;
        act(code);
        master.poll(GA, 1'b0, 16'h0, 16'h0);
        master.poll(8'h55, 1'b1, {8'h00, UA}, code);
        master.xfer(UA, 1'b1, saer_pkg::REG_OUT_STATE, 16'h0000, 1'b1, OK0);
        check({23'h0, latched}, 24'h0);
        master.xfer(UA, 1'b1, saer_pkg::REG_LATCH_TMO, 16'h0000, 1'b1, OK0);
        master.xfer(UA, 1'b0, saer_pkg::REG_LATCH_TMO, 16'h0, 1'b1, OK0);
        act(xs() | 16'h0001);
        n = 0;
        while (latched === 1'b1 && n < 100010) begin
            @(posedge clk_sys);
            n++;
        end
        check({23'h0, latched}, 24'h0);
        master.poll(UA, 1'b1, {8'h00, UA}, 16'h0000);
        repeat (6) @(posedge clk_sys);
        check(24'(master.expQ.size()), 24'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
